// ---- src/smbus_tgt_pkg.sv ----
// Behaviour
// (RL1) respond and allow register access only while select is high; otherwise ignore bus
// (RL2) host holds select low while talking to any other bus target
// (RL3) the bus port keeps working in low-power standby
// (RL4) answer only 7-bit address 1010110; write byte 0xac, read byte 0xad
// (RL5) data line stays stable while clock high, except at start and stop
// (RL6) data falling while clock high is a start; begin a new message
// (RL7) data rising while clock high is a stop; end the message
// (RL8) go idle after bus-free time past stop, or past maximum clock-high time
// (RL9) host write: start, address+0, register address, data byte, stop
// (RL10) acknowledge address, register address and written data by pulling data low
// (RL11) read: register address, repeated start, address+1, ack, data, host nack, stop
// (RL12) host raises select before start and lowers it after the stop
// (RL13) support single-register writes and reads; read-only registers return contents
// (RL14) clock held low 25 to 35 ms aborts the transaction and releases bus
// (RL15) never stretch the clock beyond 2 ms cumulative in one message
// (RL16) port ready for transactions within 500 ms of reset release
// (RL17) select gates the serial clock before it reaches the port logic
// (RL18) writes to read-only or unused addresses acked, ignored; unused reads return zero
// (RL19) data line released unless driving ack or read zeros; never driven high
package smbus_tgt_pkg;

  localparam logic [6:0] TARGET_ADDR = 7'h56;

  localparam int CLK_MHZ = 40;
  localparam int T_BUF_NS = 4700;
  localparam int T_HIGH_MAX_NS = 50000;
  localparam int T_TIMEOUT_MS = 25;
  localparam int T_POR_MS = 500;
  localparam int TARGET_CLOCK_STRETCH_LIMIT_MS = 2;

  // least times round up, longest times round down
  localparam int BUF_CYC = (T_BUF_NS * CLK_MHZ + 999) / 1000;
  localparam int HIGH_MAX_CYC = (T_HIGH_MAX_NS * CLK_MHZ) / 1000;
  localparam int TIMEOUT_CYC = T_TIMEOUT_MS * CLK_MHZ * 1000;
  localparam int POR_CYC = T_POR_MS * CLK_MHZ * 1000;

  localparam logic [7:0] REG_STATUS0 = 8'h00;
  localparam logic [7:0] REG_STATUS2 = 8'h02;
  localparam logic [7:0] REG_RW_FIRST = 8'h03;
  localparam logic [7:0] REG_RW_LAST = 8'h08;
  localparam int RW_COUNT = 6;

  localparam logic [7:0] RST_CH01_BOOST = 8'h77;
  localparam logic [7:0] RST_CH23_BOOST = 8'h77;
  localparam logic [7:0] RST_SD_ON = 8'h00;
  localparam logic [7:0] RST_SD_OFF = 8'h00;
  localparam logic [7:0] RST_EN_SOURCE = 8'h00;
  localparam logic [7:0] RST_OUT_LEVEL = 8'h78;

  localparam logic [3:0] BIT_LAST_DATA = 4'h8;
  localparam logic [3:0] BIT_LAST_ACK = 4'h9;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_REG,
    ST_WDATA,
    ST_RDATA,
    ST_IGNORE
  } tgt_state_e;

endpackage

// ---- src/smbus_pin_sync.sv ----
`timescale 1ns/100ps
module smbus_pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] ff1_reg;
  logic [WIDTH-1:0] ff2_reg;
  logic [WIDTH-1:0] ff3_reg;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      ff1_reg <= RESET_VAL;
      ff2_reg <= RESET_VAL;
      ff3_reg <= RESET_VAL;
    end else begin
      ff1_reg <= async_i;
      ff2_reg <= ff1_reg;
      ff3_reg <= ff2_reg;
    end
  end

  // a bit only moves once two later stages agree, filtering single-cycle glitches
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      sync_o <= RESET_VAL;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (ff2_reg[i] == ff3_reg[i]) begin
          sync_o[i] <= ff3_reg[i];
        end
      end
    end
  end

endmodule

// ---- src/smbus_link_shifter.sv ----
`timescale 1ns/100ps
module smbus_link_shifter (
  input wire logic link_clk_i,
  input wire logic sda_i,
  output logic [7:0] shift_o
);

  // data only, no reset: the link clock may be stopped while the system resets
  always_ff @(posedge link_clk_i) begin
    shift_o <= {shift_o[6:0], sda_i};
  end

endmodule

// ---- src/smbus_select_gated_target_port.sv ----
`timescale 1ns/100ps
module smbus_select_gated_target_port #(
  parameter int TIMEOUT_CYCLES = smbus_tgt_pkg::TIMEOUT_CYC
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic serial_clock_pin_i,
  input wire logic sda_i,
  input wire logic select_i,
  input wire logic standby_i,
  input wire logic [23:0] status_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  output logic bus_idle_o,
  output logic port_ready_o,
  output logic timeout_o,
  output logic [47:0] cfg_o
);

  logic link_clk;
  logic [7:0] link_byte;
  logic scl_s;
  logic sda_s;
  logic sel_s;
  logic scl_prev_reg;
  logic sda_prev_reg;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic abort;
  logic idle_set;
  logic timeout_hit;
  smbus_tgt_pkg::tgt_state_e state_reg;
  logic [3:0] bit_cnt_reg;
  logic sda_drv_reg;
  logic dir_reg;
  logic host_nack_reg;
  logic [7:0] ptr_reg;
  logic [7:0] tx_reg;
  logic wr_en_reg;
  logic [7:0] wr_data_reg;
  logic [7:0] rw_reg [smbus_tgt_pkg::RW_COUNT];
  logic [31:0] low_cnt_reg;
  logic [31:0] high_cnt_reg;
  logic stop_seen_reg;
  logic idle_reg;
  logic ready_reg;
  logic [7:0] rd_cur;
  logic [7:0] rd_nxt;

  // gated clock: a deselected port sees no clock edges at all
  assign link_clk = serial_clock_pin_i & select_i; // RL17

  smbus_link_shifter u_shift (
    .link_clk_i(link_clk),
    .sda_i(sda_i),
    .shift_o(link_byte)
  );

  smbus_pin_sync #(
    .WIDTH(3),
    .RESET_VAL(3'h6)
  ) u_sync (
    .clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .async_i({link_clk, sda_i, select_i}),
    .sync_o({scl_s, sda_s, sel_s})
  );

  function automatic logic [7:0] rd_value(input logic [7:0] addr, input logic [23:0] st,
                                          input logic [47:0] cfg);
    logic [7:0] v;
    v = 8'h00;
    if (addr <= smbus_tgt_pkg::REG_STATUS2) begin
      v = st[addr[1:0]*8 +: 8]; // RL13
    end else if (addr <= smbus_tgt_pkg::REG_RW_LAST) begin
      v = cfg[(addr - smbus_tgt_pkg::REG_RW_FIRST)*8 +: 8];
    end
    return v; // RL18
  endfunction

  // current and following register, so the first bit is ready at the ack's falling edge
  assign rd_cur = rd_value(ptr_reg, status_i, cfg_o);
  assign rd_nxt = rd_value(ptr_reg + 8'h01, status_i, cfg_o);

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_prev_reg <= scl_s;
      sda_prev_reg <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_prev_reg;
  assign scl_fall = ~scl_s & scl_prev_reg;
  assign start_det = sel_s & scl_s & scl_prev_reg & sda_prev_reg & ~sda_s; // RL6
  assign stop_det = sel_s & scl_s & scl_prev_reg & ~sda_prev_reg & sda_s; // RL7
  assign timeout_hit = (low_cnt_reg == 32'(TIMEOUT_CYCLES - 1));
  // standby_i deliberately plays no part: the port stays live in standby
  assign abort = ~sel_s | timeout_hit | idle_set; // RL1 RL3

  // protocol engine; the byte in link_byte is stable from the 8th rising edge
  // to the next one, so sampling it after the synced falling edge is safe
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      state_reg <= smbus_tgt_pkg::ST_IDLE;
      bit_cnt_reg <= 4'h0;
      sda_drv_reg <= 1'b0;
      dir_reg <= 1'b0;
      host_nack_reg <= 1'b1;
      ptr_reg <= 8'h00;
      tx_reg <= 8'h00;
      wr_en_reg <= 1'b0;
      wr_data_reg <= 8'h00;
    end else begin
      wr_en_reg <= 1'b0;
      if (abort) begin
        state_reg <= smbus_tgt_pkg::ST_IDLE; // RL1 RL14
        bit_cnt_reg <= 4'h0;
        sda_drv_reg <= 1'b0;
      end else if (start_det) begin
        state_reg <= smbus_tgt_pkg::ST_ADDR; // RL6
        bit_cnt_reg <= 4'h0;
        sda_drv_reg <= 1'b0;
      end else if (stop_det) begin
        state_reg <= smbus_tgt_pkg::ST_IDLE; // RL7
        bit_cnt_reg <= 4'h0;
        sda_drv_reg <= 1'b0;
      end else if (state_reg != smbus_tgt_pkg::ST_IDLE && state_reg != smbus_tgt_pkg::ST_IGNORE) begin
        if (scl_rise) begin
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
          if (state_reg == smbus_tgt_pkg::ST_RDATA && bit_cnt_reg == smbus_tgt_pkg::BIT_LAST_DATA) begin
            host_nack_reg <= sda_s; // RL11
          end
        end else if (scl_fall) begin
          if (bit_cnt_reg == smbus_tgt_pkg::BIT_LAST_DATA) begin
            case (state_reg)
              smbus_tgt_pkg::ST_ADDR: begin
                if (link_byte[7:1] == smbus_tgt_pkg::TARGET_ADDR) begin // RL4
                  sda_drv_reg <= 1'b1; // RL10
                  dir_reg <= link_byte[0];
                end else begin
                  state_reg <= smbus_tgt_pkg::ST_IGNORE;
                end
              end
              smbus_tgt_pkg::ST_REG: begin
                ptr_reg <= link_byte;
                sda_drv_reg <= 1'b1; // RL10
              end
              smbus_tgt_pkg::ST_WDATA: begin
                wr_data_reg <= link_byte;
                wr_en_reg <= 1'b1;
                sda_drv_reg <= 1'b1; // RL10
              end
              default: begin
                sda_drv_reg <= 1'b0; // RL19
              end
            endcase
          end else if (bit_cnt_reg == smbus_tgt_pkg::BIT_LAST_ACK) begin
            bit_cnt_reg <= 4'h0;
            case (state_reg)
              smbus_tgt_pkg::ST_ADDR: begin
                if (dir_reg) begin
                  state_reg <= smbus_tgt_pkg::ST_RDATA; // RL11
                  sda_drv_reg <= ~rd_cur[7];
                  tx_reg <= {rd_cur[6:0], 1'b0};
                end else begin
                  state_reg <= smbus_tgt_pkg::ST_REG;
                  sda_drv_reg <= 1'b0;
                end
              end
              smbus_tgt_pkg::ST_REG: begin
                state_reg <= smbus_tgt_pkg::ST_WDATA;
                sda_drv_reg <= 1'b0;
              end
              smbus_tgt_pkg::ST_WDATA: begin
                ptr_reg <= ptr_reg + 8'h01;
                sda_drv_reg <= 1'b0;
              end
              smbus_tgt_pkg::ST_RDATA: begin
                if (!host_nack_reg) begin
                  ptr_reg <= ptr_reg + 8'h01;
                  sda_drv_reg <= ~rd_nxt[7];
                  tx_reg <= {rd_nxt[6:0], 1'b0};
                end else begin
                  state_reg <= smbus_tgt_pkg::ST_IGNORE; // RL11
                  sda_drv_reg <= 1'b0;
                end
              end
              default: begin
                sda_drv_reg <= 1'b0;
              end
            endcase
          end else if (state_reg == smbus_tgt_pkg::ST_RDATA) begin
            // change data only after the clock has fallen, never while it is high
            sda_drv_reg <= ~tx_reg[7]; // RL5
            tx_reg <= {tx_reg[6:0], 1'b0};
          end
        end
      end
    end
  end

  // register bank; read-only and unused addresses swallow writes
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      rw_reg[0] <= smbus_tgt_pkg::RST_CH01_BOOST;
      rw_reg[1] <= smbus_tgt_pkg::RST_CH23_BOOST;
      rw_reg[2] <= smbus_tgt_pkg::RST_SD_ON;
      rw_reg[3] <= smbus_tgt_pkg::RST_SD_OFF;
      rw_reg[4] <= smbus_tgt_pkg::RST_EN_SOURCE;
      rw_reg[5] <= smbus_tgt_pkg::RST_OUT_LEVEL;
    end else if (wr_en_reg && ptr_reg >= smbus_tgt_pkg::REG_RW_FIRST
                 && ptr_reg <= smbus_tgt_pkg::REG_RW_LAST) begin // RL18
      rw_reg[3'(ptr_reg - smbus_tgt_pkg::REG_RW_FIRST)] <= wr_data_reg; // RL13
    end
  end

  always_comb begin
    for (int i = 0; i < smbus_tgt_pkg::RW_COUNT; i++) begin
      cfg_o[i*8 +: 8] = rw_reg[i];
    end
  end

  // clock-low timeout; only counted inside a message while selected
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      low_cnt_reg <= 32'h0;
    end else if (sel_s && !scl_s && state_reg != smbus_tgt_pkg::ST_IDLE && !timeout_hit) begin
      low_cnt_reg <= low_cnt_reg + 32'h1; // RL14
    end else begin
      low_cnt_reg <= 32'h0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      timeout_o <= 1'b0;
    end else begin
      timeout_o <= timeout_hit; // RL14
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      high_cnt_reg <= 32'h0;
    end else if (scl_s && sda_s && sel_s) begin
      if (high_cnt_reg != 32'(smbus_tgt_pkg::HIGH_MAX_CYC)) begin
        high_cnt_reg <= high_cnt_reg + 32'h1;
      end
    end else begin
      high_cnt_reg <= 32'h0;
    end
  end

  assign idle_set = !idle_reg && !start_det
                    && ((stop_seen_reg && high_cnt_reg == 32'(smbus_tgt_pkg::BUF_CYC))
                        || high_cnt_reg == 32'(smbus_tgt_pkg::HIGH_MAX_CYC)); // RL8

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      stop_seen_reg <= 1'b0;
      idle_reg <= 1'b1;
    end else begin
      if (stop_det) begin
        stop_seen_reg <= 1'b1;
      end else if (start_det) begin
        stop_seen_reg <= 1'b0;
      end
      if (start_det) begin
        idle_reg <= 1'b0;
      end else if (idle_set) begin
        idle_reg <= 1'b1; // RL8
      end
    end
  end

  // ready one cycle after reset release, far inside the power-up limit
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      ready_reg <= 1'b0;
    end else begin
      ready_reg <= 1'b1; // RL16
    end
  end

  assign port_ready_o = ready_reg;
  assign bus_idle_o = idle_reg;
  // open drain: the pin level is only ever pulled low; serial clock is input only,
  // so the port can never stretch it
  assign sda_o = 1'b0; // RL19 RL15
  assign sda_oe_n_o = ~sda_drv_reg; // RL19

endmodule

// ---- verification/smbus_host_model.sv ----
`timescale 1ns/100ps
module smbus_host_model #(
  parameter int HALF = 200
) (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o,
  output logic sel_o
);
  // open drain: a 1 releases the line to the pull-up
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
    sel_o = 1'b0;
  end
  task automatic hw(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic choose(input logic s);
    sel_o <= s;
    hw(HALF);
  endtask
  task automatic start();
    sda_o <= 1'b1;
    hw(HALF);
    scl_o <= 1'b1;
    hw(HALF);
    sda_o <= 1'b0;
    hw(HALF);
    scl_o <= 1'b0;
    hw(12);
  endtask
  task automatic stop();
    sda_o <= 1'b0;
    hw(HALF);
    scl_o <= 1'b1;
    hw(HALF);
    sda_o <= 1'b1;
    hw(HALF);
  endtask
  // data moves only with the clock low, after a hold of 300 ns
  task automatic bit_io(input logic b, output logic s);
    sda_o <= b;
    hw(HALF);
    scl_o <= 1'b1;
    s = sda_i;
    hw(HALF);
    scl_o <= 1'b0;
    hw(12);
  endtask
  task automatic put(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'b1, s);
    ack = ~s;
  endtask
  task automatic get(output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, b[i]);
    end
    bit_io(1'b1, s);
  endtask
  task automatic wr(input logic [7:0] dev, ra, d, output logic [2:0] k);
    choose(1'b1);
    start();
    put(dev, k[2]);
    put(ra, k[1]);
    put(d, k[0]);
    stop();
    choose(1'b0);
  endtask
  task automatic rd(input logic [7:0] ra, output logic [7:0] q, output logic [2:0] k);
    choose(1'b1);
    start();
    put(8'hac, k[2]);
    put(ra, k[1]);
    start();
    put(8'had, k[0]);
    get(q);
    stop();
    choose(1'b0);
  endtask
  task automatic probe(input logic s, input logic [7:0] dev, output logic ack);
    choose(s);
    start();
    put(dev, ack);
    stop();
    choose(1'b0);
  endtask
  // long idle first so the clock-high limit is exercised too
  task automatic hang(input int n, output logic ack);
    choose(1'b1);
    hw(2100);
    start();
    put(8'hac, ack);
    hw(n);
    scl_o <= 1'b1;
    hw(HALF);
    choose(1'b0);
  endtask
endmodule

// ---- verification/smbus_port_monitor.sv ----
`timescale 1ns/100ps
module smbus_port_monitor #(
  parameter int TIMEOUT_CYCLES = smbus_tgt_pkg::TIMEOUT_CYC
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic serial_clock_pin_i,
  input wire logic sda_i,
  input wire logic select_i,
  input wire logic sda_o,
  input wire logic sda_oe_n_o,
  input wire logic bus_idle_o,
  input wire logic port_ready_o,
  input wire logic timeout_o
);
  int low_cnt;
  int hi_cnt;
  // raw pins lead the synchronised view by a few cycles
  always_ff @(posedge sys_clk_i) begin
    low_cnt <= serial_clock_pin_i ? 0 : low_cnt + 1;
  end
  always_ff @(posedge sys_clk_i) begin
    hi_cnt <= (reset_n_i && select_i && serial_clock_pin_i && sda_i) ? hi_cnt + 1 : 0;
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  a_ready_release: assert property ($rose(reset_n_i) |=> port_ready_o)
    else $error("not ready after reset");
  a_ready_stays: assert property (port_ready_o |=> port_ready_o)
    else $error("ready dropped");
  a_never_high: assert property (sda_o == 1'b0)
    else $error("data driven high");
  a_unselected_quiet: assert property ((!select_i) [*8] |-> sda_oe_n_o)
    else $error("driving while unselected");
  a_drive_clock_low: assert property ($fell(sda_oe_n_o) |-> !serial_clock_pin_i && !$past(serial_clock_pin_i, 3))
    else $error("drive began with clock high");
  a_drive_selected: assert property ($fell(sda_oe_n_o) |-> select_i && $past(select_i, 8))
    else $error("drive without select");
  a_timeout_cause: assert property (timeout_o |-> low_cnt >= TIMEOUT_CYCLES)
    else $error("early timeout");
  a_timeout_pulse: assert property (timeout_o |=> !timeout_o && sda_oe_n_o)
    else $error("timeout pulse or release wrong");
  a_idle_high_max: assert property (hi_cnt == smbus_tgt_pkg::HIGH_MAX_CYC + 10 |-> bus_idle_o)
    else $error("no idle after clock-high limit");
  a_idle_lines_high: assert property ($rose(bus_idle_o) |-> sda_i && (serial_clock_pin_i || low_cnt >= TIMEOUT_CYCLES))
    else $error("idle with lines low");
endmodule
bind smbus_select_gated_target_port smbus_port_monitor #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) monitor (
  .sys_clk_i, .reset_n_i, .serial_clock_pin_i, .sda_i, .select_i,
  .sda_o, .sda_oe_n_o, .bus_idle_o, .port_ready_o, .timeout_o
);

// ---- verification/smbus_select_gated_target_port_test.sv ----
`timescale 1ns/100ps
module smbus_select_gated_target_port_test;
  localparam int TO = 1500;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic standby = 1'b0;
  logic [23:0] status = '0;
  logic to_seen = 1'b0;
  logic scl, host_sda, sel, sda_drv, oe_n, idle, ready, tmo;
  logic [47:0] cfg;
  logic [47:0] shadow = 48'h780000007777;
  wire sda_w = host_sda & (oe_n | sda_drv);
  int error_cnt = 0;
  int cmp_count = 0;
  always #12.5 sys_clk = ~sys_clk;
  smbus_host_model host (.clk_i(sys_clk), .sda_i(sda_w), .scl_o(scl), .sda_o(host_sda), .sel_o(sel));
  smbus_select_gated_target_port #(.TIMEOUT_CYCLES(TO)) dut (
    .sys_clk_i(sys_clk), .reset_n_i(reset_n), .serial_clock_pin_i(scl), .sda_i(sda_w),
    .select_i(sel), .standby_i(standby), .status_i(status), .sda_o(sda_drv), .sda_oe_n_o(oe_n),
    .bus_idle_o(idle), .port_ready_o(ready), .timeout_o(tmo), .cfg_o(cfg)
  );
  always @(posedge sys_clk) begin
    if (tmo === 1'b1) to_seen <= 1'b1;
  end
  function automatic logic [7:0] expect_reg(input logic [7:0] ra);
    if (ra < 8'h03) return status[int'(ra) * 8 +: 8];
    if (ra <= 8'h08) return shadow[(int'(ra) - 3) * 8 +: 8];
    return 8'h00;
  endfunction
  task automatic check(input logic [47:0] seen, exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %0t %s: got %h want %h", $time, what, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // run needs about 95k cycles
  initial begin
    repeat (120000) @(posedge sys_clk);
    error_cnt++;
    wrap_up();
  end
  initial begin
    logic [7:0] a, d, q;
    logic [2:0] k;
    logic ack;
    logic [7:0] ra [3];
    void'($urandom(32'h148a));
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    check(48'(ready), 48'h1, "ready");
    check(cfg, shadow, "reset values");
    status <= 24'($urandom);
    standby <= 1'b1;
    a = 8'h03 + 8'($urandom_range(5));
    d = 8'($urandom);
    host.wr(8'hac, a, d, k);
    shadow[(int'(a) - 3) * 8 +: 8] = d;
    check(48'(k), 48'h7, "write acks");
    check(cfg, shadow, "write data");
    check(48'(idle), 48'h1, "idle");
    standby <= 1'($urandom);
    host.wr(8'hac, 8'h01, ~d, k);
    check(48'(k), 48'h7, "ro write acks");
    check(cfg, shadow, "ro write");
    ra = '{a, 8'($urandom_range(2)), 8'h20};
    foreach (ra[i]) begin
      host.rd(ra[i], q, k);
      check(48'(k), 48'h7, "read acks");
      check(48'(q), 48'(expect_reg(ra[i])), "read data");
    end
    host.probe(1'b1, 8'hae, ack);
    check(48'(ack), 48'h0, "foreign address");
    host.probe(1'b0, 8'hac, ack);
    check(48'(ack), 48'h0, "unselected");
    host.hang(TO + 300, ack);
    check(48'(to_seen), 48'h1, "timeout");
    check(48'(oe_n), 48'h1, "released");
    wrap_up();
  end
endmodule
